// ===== verilog/sfr_sys_regs.sv
// System interrupt enable and flag bytes on the core's peripheral bus
//
// Contract
// - Power-up-clear bits writable, forced by every clear
// - Power-on bits writable, forced only by power-on
// - Unassigned bit positions hold no storage
// - Enable byte holds four enables, cleared
// - Watchdog enable acts only in interval mode
// - Watchdog flag set on key violation, or on overflow outside interval mode
// - Watchdog flag cleared by power-on or pin reset
// - Oscillator flag set on fault and clear
// - Power-on flag set on power-up, software clearable
// - Pin reset flag set by pin, cleared power-on
// - Pin NMI flag set by pin, cleared
// - Individual enables gate non-maskable sources, no global
`timescale 1ns/1ps
module sfr_sys_regs
  import sfr_pkg::*;
(
  input  wire logic                      clk,               // System clock, 25 MHz
  input  wire logic                      rst_n,             // Power-up clear, sync, low
  input  wire logic                      por_n,             // Power-on reset, sync, low
  input  wire logic [sfr_pkg::ADDR_W-1:0] bus_addr,         // Byte address in SFR space
  input  wire logic                      bus_wr,            // Write strobe
  input  wire logic                      bus_rd,            // Read strobe
  input  wire logic [sfr_pkg::DATA_W-1:0] bus_wdata,        // Write byte
  output logic      [sfr_pkg::DATA_W-1:0] bus_rdata,        // Read byte, one cycle later
  input  wire logic                      wdog_overflow,     // Counter overflow pulse
  input  wire logic                      wdog_interval_mode, // Watchdog in interval mode
  input  wire logic                      wdog_key_violation, // Security key fault pulse
  input  wire logic                      osc_fault,         // Oscillator fault pulse
  input  wire logic                      pin_reset_evt,     // Reset seen on reset_nmi_pin
  input  wire logic                      pin_nmi_evt,       // NMI seen on reset_nmi_pin
  input  wire logic                      flash_violation,   // Flash violation flag level
  output logic                           wdog_irq_req,      // Watchdog interval request
  output logic                           nmi_irq_req        // Non-maskable request
);
  import sfr_pkg::*;

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    addr_hit = (a == off);
  endfunction

  logic                 flash_violation_irq_en;
  logic                 pin_nmi_irq_en;
  logic                 osc_fault_irq_en;
  logic                 wdog_interval_irq_en;
  logic [NUM_FLAGS-1:0] flag_q;
  logic [NUM_FLAGS-1:0] flag_set;
  logic [NUM_FLAGS-1:0] flag_clr;
  logic                 wr_flags;
  logic                 wr_enables;
  logic [DATA_W-1:0]    en_byte;
  logic [DATA_W-1:0]    flag_byte;

  assign wr_enables = bus_wr && addr_hit(bus_addr, OFF_EN_ONE);
  assign wr_flags   = bus_wr && addr_hit(bus_addr, OFF_FLAG_ONE);

  // Only the four enables are flip-flops; other positions have none
  always_ff @(posedge clk) begin
    if (!rst_n || !por_n) begin
      flash_violation_irq_en <= EN_RESET;
      pin_nmi_irq_en         <= EN_RESET;
      osc_fault_irq_en       <= EN_RESET;
      wdog_interval_irq_en   <= EN_RESET;
    end else if (wr_enables) begin
      flash_violation_irq_en <= bus_wdata[BIT_FLASH_EN];
      pin_nmi_irq_en         <= bus_wdata[BIT_NMI_EN];
      osc_fault_irq_en       <= bus_wdata[BIT_OSC_EN];
      wdog_interval_irq_en   <= bus_wdata[BIT_WDOG_EN];
    end
  end

  // Hardware events per flag
  always_comb begin
    flag_set = '0;
    flag_clr = '0;
    flag_set[BIT_WDOG_FLAG] = wdog_key_violation
                              || (wdog_overflow && !wdog_interval_mode);
    flag_clr[BIT_WDOG_FLAG] = pin_reset_evt;
    flag_set[BIT_OSC_FLAG]  = osc_fault;
    flag_set[BIT_PIN_RST]   = pin_reset_evt;
    flag_set[BIT_NMI_FLAG]  = pin_nmi_evt;
  end

  // Power-on flag is raised by its reset value, so no set input needed
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
      sfr_flag_cell #(
        .RESET_VAL (FLAG_RESET_VAL[gi]),
        .POR_ONLY  (FLAG_POR_ONLY[gi])
      ) u_cell (
        .clk    (clk),
        .rst_n  (rst_n),
        .por_n  (por_n),
        .hw_set (flag_set[gi]),
        .hw_clr (flag_clr[gi]),
        .wr_en  (wr_flags),
        .wr_val (bus_wdata[gi]),
        .flag_q (flag_q[gi])
      );
    end
  endgenerate

  always_comb begin
    en_byte                = READ_ZERO;
    en_byte[BIT_FLASH_EN]  = flash_violation_irq_en;
    en_byte[BIT_NMI_EN]    = pin_nmi_irq_en;
    en_byte[BIT_OSC_EN]    = osc_fault_irq_en;
    en_byte[BIT_WDOG_EN]   = wdog_interval_irq_en;
    flag_byte              = READ_ZERO;
    flag_byte[NUM_FLAGS-1:0] = flag_q;
  end

  // Unmapped and empty bytes read zero
  always_ff @(posedge clk) begin
    if (!rst_n || !por_n) begin
      bus_rdata <= READ_ZERO;
    end else if (bus_rd) begin
      if (addr_hit(bus_addr, OFF_EN_ONE)) begin
        bus_rdata <= en_byte;
      end else if (addr_hit(bus_addr, OFF_FLAG_ONE)) begin
        bus_rdata <= flag_byte;
      end else begin
        bus_rdata <= READ_ZERO;
      end
    end
  end

  sfr_irq_gate u_gate (
    .clk           (clk),
    .rst_n         (rst_n && por_n),
    .wdog_flag     (flag_q[BIT_WDOG_FLAG]),
    .wdog_en       (wdog_interval_irq_en),
    .interval_mode (wdog_interval_mode),
    .osc_flag      (flag_q[BIT_OSC_FLAG]),
    .osc_en        (osc_fault_irq_en),
    .nmi_flag      (flag_q[BIT_NMI_FLAG]),
    .nmi_en        (pin_nmi_irq_en),
    .flash_flag    (flash_violation),
    .flash_en      (flash_violation_irq_en),
    .wdog_irq_req  (wdog_irq_req),
    .nmi_irq_req   (nmi_irq_req)
  );

  a_en_puc_clear: assert property (@(posedge clk)
    !rst_n |=> (en_byte == READ_ZERO))
    else $error("Enables not cleared by power-up clear");

  a_en_write_takes: assert property (@(posedge clk) disable iff (!rst_n || !por_n)
    wr_enables |=> (en_byte == ($past(bus_wdata) & 8'h33)))
    else $error("Enable byte write not stored");

  a_unimpl_read_zero: assert property (@(posedge clk) disable iff (!rst_n || !por_n)
    (bus_rd && (addr_hit(bus_addr, OFF_EN_TWO) || addr_hit(bus_addr, OFF_FLAG_TWO)))
    |=> (bus_rdata == READ_ZERO))
    else $error("Unimplemented byte read nonzero");

  a_wdog_gate_mode: assert property (@(posedge clk) disable iff (!rst_n || !por_n)
    !wdog_interval_mode |=> !wdog_irq_req)
    else $error("Watchdog request outside interval mode");

  a_wdog_flag_set: assert property (@(posedge clk) disable iff (!por_n)
    (wdog_key_violation || (wdog_overflow && !wdog_interval_mode))
    |=> flag_q[BIT_WDOG_FLAG])
    else $error("Watchdog flag not set");

  a_wdog_flag_clr: assert property (@(posedge clk) disable iff (!por_n)
    (pin_reset_evt && !flag_set[BIT_WDOG_FLAG]) |=> !flag_q[BIT_WDOG_FLAG])
    else $error("Watchdog flag not cleared by pin reset");

  a_osc_flag_puc: assert property (@(posedge clk)
    (!rst_n || osc_fault) |=> flag_q[BIT_OSC_FLAG])
    else $error("Oscillator flag not set");

  a_power_on_flag: assert property (@(posedge clk)
    !por_n |=> (flag_q[BIT_PWR_FLAG] && !flag_q[BIT_PIN_RST] && !flag_q[BIT_WDOG_FLAG]))
    else $error("Power-on flag values wrong");

  a_pin_reset_flag: assert property (@(posedge clk) disable iff (!por_n)
    pin_reset_evt |=> flag_q[BIT_PIN_RST])
    else $error("Pin reset flag not set");

  a_nmi_flag_puc: assert property (@(posedge clk) disable iff (!por_n)
    (!rst_n && !pin_nmi_evt) |=> !flag_q[BIT_NMI_FLAG])
    else $error("Pin NMI flag not cleared");

  a_nmi_req_path: assert property (@(posedge clk) disable iff (!rst_n || !por_n)
    (flag_q[BIT_NMI_FLAG] && pin_nmi_irq_en) |=> nmi_irq_req)
    else $error("NMI request missing");

  a_req_needs_en: assert property (@(posedge clk) disable iff (!rst_n || !por_n)
    (!flash_violation_irq_en && !pin_nmi_irq_en && !osc_fault_irq_en) |=> !nmi_irq_req)
    else $error("Request without enable");

  // Enable byte: power-on clear, hold and readback
  a_en_por_clear: assert property (@(posedge clk)
    !por_n |=> (en_byte == READ_ZERO))
    else $error("Enables not cleared by power-on reset");

  a_en_hold_idle: assert property (@(posedge clk) disable iff (!rst_n || !por_n)
    !wr_enables |=> (en_byte == $past(en_byte)))
    else $error("Enable byte changed without a write");

  a_en_read_value: assert property (@(posedge clk) disable iff (!rst_n || !por_n)
    (bus_rd && addr_hit(bus_addr, OFF_EN_ONE)) |=> (bus_rdata == $past(en_byte)))
    else $error("Enable byte read wrong");

  // Read path: old value returned, held until the next read
  a_flag_read_value: assert property (@(posedge clk) disable iff (!rst_n || !por_n)
    (bus_rd && addr_hit(bus_addr, OFF_FLAG_ONE)) |=> (bus_rdata == $past(flag_byte)))
    else $error("Flag byte read wrong");

  a_high_addr_zero: assert property (@(posedge clk) disable iff (!rst_n || !por_n)
    (bus_rd && (bus_addr > OFF_FLAG_TWO)) |=> (bus_rdata == READ_ZERO))
    else $error("Unmapped byte read nonzero");

  a_rdata_holds: assert property (@(posedge clk) disable iff (!rst_n || !por_n)
    !bus_rd |=> (bus_rdata == $past(bus_rdata)))
    else $error("Read byte changed without a read");

  a_rdata_clear: assert property (@(posedge clk)
    (!rst_n || !por_n) |=> (bus_rdata == READ_ZERO))
    else $error("Read byte not cleared by reset");

  a_flag_write_takes: assert property (@(posedge clk) disable iff (!rst_n || !por_n)
    (wr_flags && (flag_set == '0) && (flag_clr == '0))
    |=> (flag_q == $past(bus_wdata[NUM_FLAGS-1:0])))
    else $error("Flag byte write not stored");

  a_flag_hold_idle: assert property (@(posedge clk) disable iff (!rst_n || !por_n)
    (!wr_flags && (flag_set == '0) && (flag_clr == '0)) |=> (flag_q == $past(flag_q)))
    else $error("Flag changed with no event or write");

  a_set_beats_write: assert property (@(posedge clk) disable iff (!por_n)
    (wr_flags && rst_n && (flag_set != '0))
    |=> ((flag_q & $past(flag_set)) == $past(flag_set)))
    else $error("Software write overrode a hardware set");

  // Power-on-only bits ride through a power-up clear
  a_pwr_puc_keep: assert property (@(posedge clk) disable iff (!por_n)
    !rst_n |=> (flag_q[BIT_PWR_FLAG] == $past(flag_q[BIT_PWR_FLAG])))
    else $error("Power-on flag changed by power-up clear");

  a_pin_puc_keep: assert property (@(posedge clk) disable iff (!por_n)
    (!rst_n && !pin_reset_evt) |=> (flag_q[BIT_PIN_RST] == $past(flag_q[BIT_PIN_RST])))
    else $error("Pin reset flag changed by power-up clear");

  a_wdog_puc_keep: assert property (@(posedge clk) disable iff (!por_n)
    (!rst_n && !pin_reset_evt && !flag_set[BIT_WDOG_FLAG])
    |=> (flag_q[BIT_WDOG_FLAG] == $past(flag_q[BIT_WDOG_FLAG])))
    else $error("Watchdog flag changed by power-up clear");

  a_pwr_only_por: assert property (@(posedge clk) disable iff (!rst_n || !por_n)
    (!wr_flags && !flag_q[BIT_PWR_FLAG]) |=> !flag_q[BIT_PWR_FLAG])
    else $error("Power-on flag rose without power-on reset");

  // Flags rise only on their own events
  a_ovf_mode_ignored: assert property (@(posedge clk) disable iff (!por_n)
    (wdog_overflow && wdog_interval_mode && !wdog_key_violation && !pin_reset_evt && !wr_flags)
    |=> (flag_q[BIT_WDOG_FLAG] == $past(flag_q[BIT_WDOG_FLAG])))
    else $error("Overflow in interval mode touched watchdog flag");

  a_osc_only_event: assert property (@(posedge clk) disable iff (!rst_n || !por_n)
    (!osc_fault && !wr_flags && !flag_q[BIT_OSC_FLAG]) |=> !flag_q[BIT_OSC_FLAG])
    else $error("Oscillator flag rose without a fault");

  a_pin_only_event: assert property (@(posedge clk) disable iff (!rst_n || !por_n)
    (!pin_reset_evt && !wr_flags && !flag_q[BIT_PIN_RST]) |=> !flag_q[BIT_PIN_RST])
    else $error("Pin reset flag rose without a pin reset");

  a_nmi_only_event: assert property (@(posedge clk) disable iff (!rst_n || !por_n)
    (!pin_nmi_evt && !wr_flags && !flag_q[BIT_NMI_FLAG]) |=> !flag_q[BIT_NMI_FLAG])
    else $error("Pin NMI flag rose without an event");

  a_nmi_flag_set: assert property (@(posedge clk) disable iff (!rst_n || !por_n)
    pin_nmi_evt |=> flag_q[BIT_NMI_FLAG])
    else $error("Pin NMI flag not set");

  // Requests follow flag and enable one cycle late
  a_wdog_req_path: assert property (@(posedge clk) disable iff (!rst_n || !por_n)
    (flag_q[BIT_WDOG_FLAG] && wdog_interval_irq_en && wdog_interval_mode) |=> wdog_irq_req)
    else $error("Watchdog interval request missing");

  a_wdog_req_needs: assert property (@(posedge clk) disable iff (!rst_n || !por_n)
    (!flag_q[BIT_WDOG_FLAG] || !wdog_interval_irq_en) |=> !wdog_irq_req)
    else $error("Watchdog request without flag and enable");

  a_osc_req_path: assert property (@(posedge clk) disable iff (!rst_n || !por_n)
    (flag_q[BIT_OSC_FLAG] && osc_fault_irq_en) |=> nmi_irq_req)
    else $error("Oscillator fault request missing");

  a_flash_req_path: assert property (@(posedge clk) disable iff (!rst_n || !por_n)
    (flash_violation && flash_violation_irq_en) |=> nmi_irq_req)
    else $error("Flash violation request missing");

  a_nmi_req_needs: assert property (@(posedge clk) disable iff (!rst_n || !por_n)
    !((flag_q[BIT_NMI_FLAG] && pin_nmi_irq_en) || (flag_q[BIT_OSC_FLAG] && osc_fault_irq_en)
      || (flash_violation && flash_violation_irq_en)) |=> !nmi_irq_req)
    else $error("Non-maskable request without flag and enable");

  a_req_reset_low: assert property (@(posedge clk)
    (!rst_n || !por_n) |=> (!wdog_irq_req && !nmi_irq_req))
    else $error("Requests not cleared by reset");
endmodule

// ===== verilog/sfr_pkg.sv
// Offsets, bit positions and reset values of the system flag and enable bytes
package sfr_pkg;
  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 8;
  // Byte offsets in the special function space
  localparam logic [3:0]  OFF_EN_ONE      = 4'h0;
  localparam logic [3:0]  OFF_EN_TWO      = 4'h1;
  localparam logic [3:0]  OFF_FLAG_ONE    = 4'h2;
  localparam logic [3:0]  OFF_FLAG_TWO    = 4'h3;
  // Enable byte fields
  localparam int          BIT_WDOG_EN     = 0;
  localparam int          BIT_OSC_EN      = 1;
  localparam int          BIT_NMI_EN      = 4;
  localparam int          BIT_FLASH_EN    = 5;
  localparam logic        EN_RESET        = 1'b0;
  // Flag byte fields, also the index of each flag cell
  localparam int          BIT_WDOG_FLAG   = 0;
  localparam int          BIT_OSC_FLAG    = 1;
  localparam int          BIT_PWR_FLAG    = 2;
  localparam int          BIT_PIN_RST     = 3;
  localparam int          BIT_NMI_FLAG    = 4;
  localparam int          NUM_FLAGS       = 5;
  // Per flag: value after reset, and whether only power-on reset forces it
  localparam logic [4:0]  FLAG_RESET_VAL  = 5'h06;
  localparam logic [4:0]  FLAG_POR_ONLY   = 5'h0D;
  localparam logic [7:0]  READ_ZERO       = 8'h00;
endpackage

// ===== verilog/sfr_flag_cell.sv
// One sticky flag bit with power-on and power-up-clear reset handling
`timescale 1ns/1ps
module sfr_flag_cell #(
  parameter logic RESET_VAL = 1'b0,
  parameter logic POR_ONLY  = 1'b0
) (
  input  wire logic clk,      // System clock
  input  wire logic rst_n,    // Power-up clear, sync, low
  input  wire logic por_n,    // Power-on reset, sync, low
  input  wire logic hw_set,   // Hardware set event
  input  wire logic hw_clr,   // Hardware clear event
  input  wire logic wr_en,    // Software write strobe
  input  wire logic wr_val,   // Software write value
  output logic      flag_q    // Flag state
);
  always_ff @(posedge clk) begin
    if (!por_n) begin
      flag_q <= RESET_VAL;
    end else if (!rst_n && !POR_ONLY) begin
      flag_q <= RESET_VAL;
    end else if (hw_set) begin
      flag_q <= 1'b1;
    end else if (hw_clr) begin
      flag_q <= 1'b0;
    end else if (wr_en && rst_n) begin
      // Core sits in reset during a clear, so no write may land
      flag_q <= wr_val;
    end
  end

  generate
    if (POR_ONLY) begin : g_por
      a_por_bit_keep: assert property (@(posedge clk) disable iff (!por_n)
        (!rst_n && !hw_set && !hw_clr) |=> (flag_q == $past(flag_q)))
        else $error("Power-on bit changed by power-up clear");
    end
  endgenerate

  a_set_wins_clear: assert property (@(posedge clk) disable iff (!por_n)
    (hw_set && (rst_n || POR_ONLY)) |=> flag_q)
    else $error("Hardware set lost against a clear");
endmodule

// ===== verilog/sfr_irq_gate.sv
// Registered interrupt requests from flags and enables
`timescale 1ns/1ps
module sfr_irq_gate (
  input  wire logic clk,            // System clock
  input  wire logic rst_n,          // Power-up clear, sync, low
  input  wire logic wdog_flag,      // Watchdog event flag
  input  wire logic wdog_en,        // Watchdog interval enable
  input  wire logic interval_mode,  // Watchdog runs as interval timer
  input  wire logic osc_flag,       // Oscillator fault flag
  input  wire logic osc_en,         // Oscillator fault enable
  input  wire logic nmi_flag,       // Pin NMI flag
  input  wire logic nmi_en,         // Pin NMI enable
  input  wire logic flash_flag,     // Flash violation flag, held elsewhere
  input  wire logic flash_en,       // Flash violation enable
  output logic      wdog_irq_req,   // Maskable watchdog request
  output logic      nmi_irq_req     // Non-maskable request
);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wdog_irq_req <= 1'b0;
    end else begin
      // Enable is meaningless while the watchdog resets the system
      wdog_irq_req <= wdog_flag && wdog_en && interval_mode;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nmi_irq_req <= 1'b0;
    end else begin
      // No global enable input: only the individual enables block these
      nmi_irq_req <= (nmi_flag && nmi_en) || (osc_flag && osc_en)
                     || (flash_flag && flash_en);
    end
  end
endmodule

// ===== tb/core_model.sv
// Processor core model issuing byte reads and writes on the system register bus
`timescale 1ns/1ps
module core_model (
  input  wire logic                       clk,        // System clock
  input  wire logic [sfr_pkg::DATA_W-1:0] bus_rdata,  // Read byte from the block
  output logic      [sfr_pkg::ADDR_W-1:0] bus_addr,   // Byte address
  output logic                            bus_wr,     // Write strobe
  output logic                            bus_rd,     // Read strobe
  output logic      [sfr_pkg::DATA_W-1:0] bus_wdata   // Write byte
);
  import sfr_pkg::*;
  initial begin
    bus_addr = 4'h0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_wdata = 8'h00;
  end
  // Strobes move only at falling edges so the rising edge sees them stable
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(negedge clk);
    bus_wr = 1'b0;
    bus_wdata = ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge clk);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge clk);
    bus_rd = 1'b0;
    d = bus_rdata;
  endtask
endmodule

// ===== tb/system_irq_enable_flag_regs_bench.sv
// Self-checking bench for the system enable and flag bytes
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module system_irq_enable_flag_regs_bench;
  import sfr_pkg::*;
  logic       clk, rst_n, por_n, mode, fv, ov, key, osc, prst, pnmi, wr, rd, wirq, nirq;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  int         miscompares, total_checks, cyc;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      end_sim();
    end
  end

  sfr_sys_regs sfr_sys_regs_inst (.clk(clk), .rst_n(rst_n), .por_n(por_n), .bus_addr(addr),
    .bus_wr(wr), .bus_rd(rd), .bus_wdata(wdata), .bus_rdata(rdata), .wdog_overflow(ov),
    .wdog_interval_mode(mode), .wdog_key_violation(key), .osc_fault(osc),
    .pin_reset_evt(prst), .pin_nmi_evt(pnmi), .flash_violation(fv),
    .wdog_irq_req(wirq), .nmi_irq_req(nirq));
  core_model core_model_inst (.clk(clk), .bus_rdata(rdata), .bus_addr(addr), .bus_wr(wr),
    .bus_rd(rd), .bus_wdata(wdata));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    core_model_inst.rd(a, d);
    `CHK(d, e)
  endtask
  // Event order: nmi, pin reset, osc fault, key violation, overflow
  task automatic pulse(input logic [4:0] v);
    @(negedge clk);
    {pnmi, prst, osc, key, ov} = v;
    @(negedge clk);
    {pnmi, prst, osc, key, ov} = 5'h00;
  endtask
  task automatic t_reset();
    rdchk(4'h0, 8'h00);
    rdchk(4'h2, 8'h06);
    rdchk(4'h1, 8'h00);
  endtask
  task automatic t_access();
    core_model_inst.wr(4'h0, 8'hFF);
    rdchk(4'h0, 8'h33);
    core_model_inst.wr(4'h3, 8'hFF);
    rdchk(4'h3, 8'h00);
    core_model_inst.wr(4'hF, 8'hFF);
    rdchk(4'hF, 8'h00);
    core_model_inst.wr(4'h2, 8'hFF);
    rdchk(4'h2, 8'h1F);
    core_model_inst.wr(4'h2, 8'h00);
    rdchk(4'h2, 8'h00);
  endtask
  task automatic t_events();
    pulse(5'h01);
    rdchk(4'h2, 8'h01);
    core_model_inst.wr(4'h2, 8'h00);
    mode = 1'b1;
    pulse(5'h01);
    rdchk(4'h2, 8'h00);
    pulse(5'h02);
    rdchk(4'h2, 8'h01);
    pulse(5'h08);
    rdchk(4'h2, 8'h08);
    pulse(5'h04);
    pulse(5'h10);
    rdchk(4'h2, 8'h1A);
  endtask
  task automatic t_irq();
    core_model_inst.wr(4'h0, 8'h00);
    wt(2);
    `CHK(nirq, 1'b0)
    core_model_inst.wr(4'h0, 8'h10);
    wt(2);
    `CHK(nirq, 1'b1)
    core_model_inst.wr(4'h2, 8'h00);
    wt(2);
    `CHK(nirq, 1'b0)
    fv = 1'b1;
    core_model_inst.wr(4'h0, 8'h20);
    wt(2);
    `CHK(nirq, 1'b1)
    fv = 1'b0;
    core_model_inst.wr(4'h0, 8'h03);
    pulse(5'h06);
    wt(2);
    `CHK(wirq, 1'b1)
    `CHK(nirq, 1'b1)
    mode = 1'b0;
    wt(2);
    `CHK(wirq, 1'b0)
  endtask
  task automatic t_race();
    fork
      core_model_inst.wr(4'h2, 8'h00);
      pulse(5'h10);
    join
    rdchk(4'h2, 8'h10);
    pulse(5'h0A);
    rdchk(4'h2, 8'h19);
  endtask
  task automatic t_puc();
    core_model_inst.wr(4'h2, 8'h1F);
    core_model_inst.wr(4'h0, 8'h33);
    @(negedge clk);
    rst_n = 1'b0;
    wt(2);
    rst_n = 1'b1;
    rdchk(4'h0, 8'h00);
    rdchk(4'h2, 8'h0F);
    @(negedge clk);
    por_n = 1'b0;
    wt(2);
    por_n = 1'b1;
    rdchk(4'h2, 8'h06);
  endtask

  initial begin
    {rst_n, por_n, mode, fv, pnmi, prst, osc, key, ov} = 9'h000;
    wt(10);
    rst_n = 1'b1;
    por_n = 1'b1;
    t_reset();
    t_access();
    t_events();
    t_irq();
    t_race();
    t_puc();
    end_sim();
  end
endmodule
